//--- shared/spgp_pkg.sv
// Package: register map, field layout and reset values of the GPIO port
`default_nettype none
package spgp_pkg;
    // ***********************************************************
    // Register map
    // ***********************************************************
    localparam logic [11:0] SPGP_FUNC_OFFSET = 12'h418; // Function select
    localparam logic [11:0] SPGP_DIR_OFFSET  = 12'h41c; // Direction config
    localparam logic [11:0] SPGP_VAL_OFFSET  = 12'h420; // Pin value
    localparam int          SPGP_PINS        = 16;      // Pin count
    localparam int          SPGP_FIELD_LSB   = 0;       // Live field low bit
    localparam logic [15:0] SPGP_FUNC_RESET  = 16'h0000; // All plain I/O
    localparam logic [15:0] SPGP_DIR_RESET   = 16'h0000; // All inputs
    localparam logic [15:0] SPGP_OUT_RESET   = 16'h0000; // Output latch
    localparam logic [15:0] SPGP_RSVD_VALUE  = 16'h0000; // Bits 31:16

    // ***********************************************************
    // Bus carriers
    // ***********************************************************
    typedef struct packed {
        logic [11:0] addr;  // Byte address
        logic [31:0] wdata; // Write data
        logic        wr;    // Write strobe
        logic        rd;    // Read strobe
    } spgp_req_t;

    typedef struct packed {
        logic [15:0] oe;    // Per-pin output enable
        logic [15:0] o;     // Per-pin output level
    } spgp_drive_t;
endpackage
`default_nettype wire

//--- src/spgp_pin_mux.sv
// Module: per-pin mux choosing plain I/O or alternate-function drive
`default_nettype none
module spgp_pin_mux
    import spgp_pkg::*;
(
    input  wire logic func_sel, // One selects alternate function
    input  wire logic dir_out,  // One makes plain I/O an output
    input  wire logic gpio_val, // Plain I/O output latch
    input  wire logic alt_oe,   // Alternate function enable
    input  wire logic alt_o,    // Alternate function level
    output logic      pin_oe,   // Resulting pin enable
    output logic      pin_o     // Resulting pin level
);
    // *************************************************************
    // Selection
    // *************************************************************
    // Alternate function owns the pin; direction bit ignored
    always_comb begin
        if (func_sel) begin // [R1] [R3]
            pin_oe = alt_oe;
            pin_o  = alt_o;
        end else begin      // [R2]
            pin_oe = dir_out;
            pin_o  = gpio_val;
        end
    end
endmodule // spgp_pin_mux
`default_nettype wire

//--- src/spgp_port.sv
// Module: sixteen pin GPIO port with register access
//
// The address-and-strobe port was decided locally.
`default_nettype none
// What this block does
// R1: Function bit one selects alternate function
// R2: Direction bit one makes plain pin output
// R3: Alternate pins ignore their direction bit
// R4: Value read returns live level of pins
// R5: Value write drives only plain output pins
// R6: Function select resets to zero
// R7: Direction config resets to zero
// R8: Bits 31:16 read zero, writes ignored
module spgp_port
    import spgp_pkg::*;
#(
    parameter int PINS = SPGP_PINS // Pin count
) (
    input  wire logic        ref_clk,    // Core clock, 50 MHz
    input  wire logic        resetn,     // Async reset, active low
    input  wire logic [11:0] addr,       // Register byte address
    input  wire logic [31:0] wdata,      // Write data
    input  wire logic        wr,         // Write strobe
    input  wire logic        rd,         // Read strobe
    output logic      [31:0] rdata,      // Read data, cycle after rd
    input  wire logic [15:0] pin_i,      // Live pin levels
    output logic      [15:0] pin_o,      // Pin drive levels
    output logic      [15:0] pin_oe,     // Pin drive enables
    input  wire logic [15:0] alt_o,      // Alternate function levels
    input  wire logic [15:0] alt_oe      // Alternate function enables
);
    // *************************************************************
    // State
    // *************************************************************
    spgp_req_t   req;          // Gathered bus request
    logic [15:0] func_sel;     // Function select field
    logic [15:0] dir_cfg;      // Direction config field
    logic [15:0] out_latch;    // Output value latch
    logic [31:0] next_rdata;   // Next read data
    logic [15:0] next_func;    // Next function select
    logic [15:0] next_dir;     // Next direction config
    logic [15:0] next_out;     // Next output latch
    spgp_drive_t mux_drive;    // Combined pin drive
    spgp_drive_t next_drive;   // Drive to register

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // *************************************************************
    // Register writes
    // *************************************************************
    // Only low 16 bits are stored, upper write bits dropped
    always_comb begin
        next_func = func_sel;
        next_dir  = dir_cfg;
        next_out  = out_latch;
        if (req.wr) begin
            unique case (req.addr)
                SPGP_FUNC_OFFSET: begin // [R8]
                    next_func = req.wdata[15:0];
                end
                SPGP_DIR_OFFSET: begin  // [R8]
                    next_dir = req.wdata[15:0];
                end
                SPGP_VAL_OFFSET: begin  // [R5]
                    // Latch all bits; only plain outputs reach pins
                    next_out = req.wdata[15:0];
                end
                default: begin
                    // Unmapped address: write ignored
                end
            endcase
        end
    end

    // *************************************************************
    // Read mux
    // *************************************************************
    // Upper half is reserved and reads zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                SPGP_FUNC_OFFSET: next_rdata = {SPGP_RSVD_VALUE, func_sel};
                SPGP_DIR_OFFSET:  next_rdata = {SPGP_RSVD_VALUE, dir_cfg};
                SPGP_VAL_OFFSET: next_rdata = {SPGP_RSVD_VALUE, pin_i}; // [R4]
                default:          next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // *************************************************************
    // Pin muxes
    // *************************************************************
    // One mux per pin; outputs registered below
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        spgp_pin_mux u_mux (
            .func_sel (next_func[g]),
            .dir_out  (next_dir[g]),
            .gpio_val (next_out[g]),
            .alt_oe   (alt_oe[g]),
            .alt_o    (alt_o[g]),
            .pin_oe   (mux_drive.oe[g]),
            .pin_o    (mux_drive.o[g])
        );
    end

    always_comb begin
        next_drive = mux_drive; // [R2] [R3]
    end

    // *************************************************************
    // Registers
    // *************************************************************
    // Reset leaves every pin a plain input, nothing driven
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            func_sel  <= SPGP_FUNC_RESET; // [R6]
            dir_cfg   <= SPGP_DIR_RESET;  // [R7]
            out_latch <= SPGP_OUT_RESET;
            rdata     <= 32'h0000_0000;
            pin_o     <= 16'h0000;
            pin_oe    <= 16'h0000;
        end else begin
            func_sel  <= next_func;
            dir_cfg   <= next_dir;
            out_latch <= next_out;
            rdata     <= next_rdata;
            pin_o     <= next_drive.o;
            pin_oe    <= next_drive.oe;
        end
    end

    // *************************************************************
    // Assertions
    // *************************************************************
    property p_func_route;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 (func_sel[0] && $past(alt_oe[0]) ) |-> pin_oe[0];
    endproperty
    a_func_route: assert property (p_func_route) // [R1]
        else $error("Alternate pin not following its function");

    property p_dir_out;
        @(posedge ref_clk) disable iff (!resetn)
        (!func_sel[0]) |-> (pin_oe[0] == dir_cfg[0]);
    endproperty
    a_dir_out: assert property (p_dir_out) // [R2]
        else $error("Plain pin enable differs from direction bit");

    property p_alt_ignores_dir;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 func_sel[1] |-> (pin_oe[1] == $past(alt_oe[1])
                             && pin_o[1] == $past(alt_o[1]));
    endproperty
    a_alt_ignores_dir: assert property (p_alt_ignores_dir) // [R3]
        else $error("Alternate pin influenced by direction bit");

    property p_read_live;
        @(posedge ref_clk) disable iff (!resetn)
        (rd && addr == SPGP_VAL_OFFSET) |=> (rdata[15:0] == $past(pin_i));
    endproperty
    a_read_live: assert property (p_read_live) // [R4]
        else $error("Value read not equal to live pins");

    property p_write_drive;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && addr == SPGP_VAL_OFFSET && !func_sel[2] && dir_cfg[2]
         && !(wr && addr == SPGP_FUNC_OFFSET))
        |=> (pin_o[2] == $past(wdata[2]) && pin_oe[2]);
    endproperty
    a_write_drive: assert property (p_write_drive) // [R5]
        else $error("Written value not driven on plain output");

    property p_plain_input_quiet;
        @(posedge ref_clk) disable iff (!resetn)
        (!func_sel[3] && !dir_cfg[3]) |-> !pin_oe[3];
    endproperty
    a_plain_input_quiet: assert property (p_plain_input_quiet) // [R5]
        else $error("Plain input pin is driven");

    property p_reset_func;
        @(posedge ref_clk) $rose(resetn) |-> (func_sel == 16'h0000);
    endproperty
    a_reset_func: assert property (p_reset_func) // [R6]
        else $error("Function select not zero after reset");

    property p_reset_dir;
        @(posedge ref_clk) $rose(resetn) |-> (dir_cfg == 16'h0000);
    endproperty
    a_reset_dir: assert property (p_reset_dir) // [R7]
        else $error("Direction config not zero after reset");

    property p_rsvd_zero;
        @(posedge ref_clk) disable iff (!resetn)
        rdata[31:16] == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // [R8]
        else $error("Reserved bits read nonzero");

    // *************************************************************
    // Register update checks
    // *************************************************************
    // Live low half of a write lands one edge later
    property p_func_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && addr == SPGP_FUNC_OFFSET)
        |=> (func_sel == $past(wdata[15:0]));
    endproperty
    a_func_write: assert property (p_func_write) // [R1]
        else $error("Function select write did not land");

    // Direction bits follow the same path
    property p_dir_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && addr == SPGP_DIR_OFFSET)
        |=> (dir_cfg == $past(wdata[15:0]));
    endproperty
    a_dir_write: assert property (p_dir_write) // [R2]
        else $error("Direction config write did not land");

    // Latch keeps all bits, even for input pins
    property p_val_latch;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && addr == SPGP_VAL_OFFSET)
        |=> (out_latch == $past(wdata[15:0]));
    endproperty
    a_val_latch: assert property (p_val_latch) // [R5]
        else $error("Value write not latched");

    // Unmapped write must leave every field alone
    property p_unmapped_write;
        @(posedge ref_clk) disable iff (!resetn)
        (wr && addr != SPGP_FUNC_OFFSET && addr != SPGP_DIR_OFFSET
         && addr != SPGP_VAL_OFFSET)
        |=> ($stable(func_sel) && $stable(dir_cfg) && $stable(out_latch));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // [R8]
        else $error("Unmapped write changed a field");

    // Read data stands one cycle only, zero otherwise
    property p_rdata_idle;
        @(posedge ref_clk) disable iff (!resetn)
        !rd |=> (rdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [R8]
        else $error("Read data not zero outside a read");

    // Released reset leaves nothing driven
    property p_reset_pins;
        @(posedge ref_clk) $rose(resetn) |-> (pin_oe == 16'h0000);
    endproperty
    a_reset_pins: assert property (p_reset_pins) // [R7]
        else $error("Pin driven straight after reset");

    // *************************************************************
    // Per-pin checks
    // *************************************************************
    // Every pin gets the same four checks, not just a sample of them
    // Scoped names keep each pin's labels apart
    for (genvar k = 0; k < PINS; k++) begin : g_chk
        // Alternate pins copy the function's drive, one edge late
        property p_pin_alt;
            @(posedge ref_clk) disable iff (!resetn)
            ##1 func_sel[k] |-> (pin_oe[k] == $past(alt_oe[k])
                                 && pin_o[k] == $past(alt_o[k]));
        endproperty
        a_pin_alt: assert property (p_pin_alt) // [R3]
            else $error("Alternate pin drive mismatch");

        // Plain pins take their enable from the direction bit
        property p_pin_plain;
            @(posedge ref_clk) disable iff (!resetn)
            !func_sel[k] |-> (pin_oe[k] == dir_cfg[k]);
        endproperty
        a_pin_plain: assert property (p_pin_plain) // [R2]
            else $error("Plain pin enable mismatch");

        // Plain outputs show the latched value
        property p_pin_level;
            @(posedge ref_clk) disable iff (!resetn)
            (!func_sel[k] && dir_cfg[k]) |-> (pin_o[k] == out_latch[k]);
        endproperty
        a_pin_level: assert property (p_pin_level) // [R5]
            else $error("Plain output level mismatch");

        // Plain inputs stay undriven whatever was written
        property p_pin_quiet;
            @(posedge ref_clk) disable iff (!resetn)
            (!func_sel[k] && !dir_cfg[k]) |-> !pin_oe[k];
        endproperty
        a_pin_quiet: assert property (p_pin_quiet) // [R5]
            else $error("Plain input pin driven");
    end

    c_write_func: cover property (@(posedge ref_clk) disable iff (!resetn)
        wr && addr == SPGP_FUNC_OFFSET);
    c_read_val: cover property (@(posedge ref_clk) disable iff (!resetn)
        rd && addr == SPGP_VAL_OFFSET);
    c_drive_out: cover property (@(posedge ref_clk) disable iff (!resetn)
        pin_oe[2] && !func_sel[2]);
    // Alternate function seen owning a pin
    c_alt_pin: cover property (@(posedge ref_clk) disable iff (!resetn)
        func_sel[0] && pin_oe[0]);
endmodule // spgp_port
`default_nettype wire

//--- test/spgp_port_test.sv
// Testbench: self-checking bench for the sixteen pin GPIO port
`default_nettype none
module spgp_port_test
    import spgp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************************************
    // Stimulus, design outputs and bench model
    // ***********************************************************
    logic        ref_clk = 1'b0;   // Core clock, 20 ns
    logic        resetn  = 1'b0;   // Held low at start
    logic [11:0] addr    = 12'h000; // Bus address
    logic [31:0] wdata   = 32'h0;  // Bus write data
    logic        wr      = 1'b0;   // Write strobe
    logic        rd      = 1'b0;   // Read strobe
    logic [15:0] pin_i   = 16'h0;  // Live pin levels
    logic [15:0] alt_o   = 16'h0;  // Alternate levels
    logic [15:0] alt_oe  = 16'h0;  // Alternate enables
    logic [31:0] rdata;            // Read data
    logic [15:0] pin_o;            // Pin drive level
    logic [15:0] pin_oe;           // Pin drive enable
    logic [15:0] m_func  = 16'h0;  // Model function select
    logic [15:0] m_dir   = 16'h0;  // Model direction
    logic [15:0] m_lat   = 16'h0;  // Model output latch
    logic [31:0] lfsr    = 32'h0001_27eb; // Random state
    logic [11:0] offs [4] = '{12'h418, 12'h41c, 12'h420, 12'h424};
    int          n_fail    = 0;    // Mismatch count
    int          tests_run = 0;    // Comparison count

    always #10 ref_clk = ~ref_clk; // Free running clock

    spgp_port #(.PINS(SPGP_PINS)) spgp_port_inst (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .alt_o(alt_o), .alt_oe(alt_oe));

    // ***********************************************************
    // Helpers
    // ***********************************************************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin // Four-state compare
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write; model keeps only the live low half
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
        if (a == SPGP_FUNC_OFFSET) m_func = d[15:0];
        if (a == SPGP_DIR_OFFSET) m_dir = d[15:0];
        if (a == SPGP_VAL_OFFSET) m_lat = d[15:0];
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk_regs();
        logic [31:0] v;
        bus_rd(SPGP_FUNC_OFFSET, v);
        chk(v, {16'h0, m_func});
        bus_rd(SPGP_DIR_OFFSET, v);
        chk(v, {16'h0, m_dir});
        bus_rd(SPGP_VAL_OFFSET, v);
        chk(v, {16'h0, pin_i});
        bus_rd(12'h424, v);
        chk(v, 32'h0);
    endtask

    // Two edges let registered pin outputs follow alternate inputs
    task automatic chk_pins();
        logic [15:0] eoe;
        logic [15:0] eo;
        repeat (2) @(posedge ref_clk);
        #1;
        eoe = (m_func & alt_oe) | (~m_func & m_dir);
        eo  = (m_func & alt_o) | (~m_func & m_lat);
        chk({16'h0, pin_oe}, {16'h0, eoe});
        chk({16'h0, pin_o & eoe}, {16'h0, eo & eoe});
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ***********************************************************
    // Main sequence and watchdog
    // ***********************************************************
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        chk_regs();
        chk_pins();
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk);
            pin_i  <= 16'(rnd());
            alt_o  <= 16'(rnd());
            alt_oe <= 16'(rnd());
            bus_wr(offs[i % 4], rnd()); // Reserved bits random too
            chk_regs();
            chk_pins();
            // Mid-run reset brings config back to plain inputs
            if (i == 40) begin
                @(posedge ref_clk);
                resetn <= 1'b0;
                repeat (4) @(posedge ref_clk);
                resetn <= 1'b1;
                m_func = 16'h0;
                m_dir  = 16'h0;
                m_lat  = 16'h0;
                chk_regs();
                chk_pins();
            end
        end
        tally_and_finish();
    end

    // Whole run is about 800 cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule // spgp_port_test
`default_nettype wire
